// File: freq_meter_pkg.sv
// Constants, field layouts and source codes shared by the frequency meter
package freq_meter_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [9:0] OFS_CTRL   = 10'h000;
  localparam logic [9:0] OFS_MODE   = 10'h004;
  localparam logic [9:0] OFS_STATUS = 10'h008;
  localparam logic [9:0] OFS_VALUE  = 10'h00c;
  localparam logic [9:0] OFS_IER    = 10'h010;
  localparam logic [9:0] OFS_IDR    = 10'h014;
  localparam logic [9:0] OFS_IMR    = 10'h018;
  localparam logic [9:0] OFS_ISR    = 10'h01c;
  localparam logic [9:0] OFS_ICR    = 10'h020;
  localparam logic [9:0] OFS_REV    = 10'h3fc;

  // ----------------------------------------------------------------
  // Field positions, widths and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_START_BIT = 0;
  localparam int          REFCEN_BIT     = 31;
  localparam int          MEASURED_SOURCE_SELECT_LSB     = 16;
  localparam int          MEASURED_SOURCE_SELECT_W       = 5;
  localparam int          REFNUM_LSB     = 8;
  localparam int          REFNUM_W       = 8;
  localparam int          REFERENCE_SOURCE_SELECT_LSB     = 0;
  localparam int          REFERENCE_SOURCE_SELECT_W       = 3;
  localparam int          VALUE_W        = 24;
  localparam int          IRQ_DONE_BIT   = 0;
  localparam int          IRQ_RDY_BIT    = 1;
  localparam logic [31:0] MODE_WMASK     = 32'h801f_ff07;
  localparam logic [31:0] RST_MODE       = 32'h0000_0000;
  localparam logic [1:0]  RST_IRQ        = 2'h0;
  localparam logic [3:0]  REF_SETTLE_EDGES = 4'h3;

  // ----------------------------------------------------------------
  // Source select encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MSR_CORE = 5'h00, MSR_HSB = 5'h01, MSR_PBA = 5'h02, MSR_PBB = 5'h03,
    MSR_MAIN_OSC = 5'h04, MSR_SLOW_XTAL = 5'h05, MSR_SYS_RC = 5'h06,
    MSR_PLL_A = 5'h07, MSR_PLL_B = 5'h08, MSR_GCLK_FIRST = 5'h0a,
    MSR_GCLK_LAST = 5'h12, MSR_FAST_RC_DBG = 5'h13
  } measured_src_t;

  typedef enum logic [2:0] {
    REF_SYS_RC = 3'h0, REF_SLOW_XTAL = 3'h1, REF_MAIN_OSC = 3'h2,
    REF_GCLK0 = 3'h3
  } reference_src_t;

endpackage

// File: frequency_meter.sv
// Frequency meter top: Wishbone registers, interrupts and clock source selection
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module frequency_meter
  import freq_meter_pkg::*;
#(
  parameter logic [11:0] REV_NUMBER  = 12'h5a1, // Arbitrary value
  parameter logic [3:0]  REV_VARIANT = 4'h0,    // Arbitrary value
  parameter int          MSR_SRC_W   = 20,
  parameter int          REF_SRC_W   = 4
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [9:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [MSR_SRC_W-1:0] measured_clock_src,
  input  wire logic [REF_SRC_W-1:0] reference_clock_src,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RS_OFF    = 3'b001,
    RS_SETTLE = 3'b010,
    RS_READY  = 3'b100
  } ref_state_t;

  meter_if mif ();

  logic                ack_ff;
  logic [31:0]         rdata_ff;
  logic [31:0]         mode_ff;
  logic [31:0]         nxt_mode;
  logic [1:0]          mask_ff;
  logic [1:0]          nxt_mask;
  logic [1:0]          pend_ff;
  logic [1:0]          nxt_pend;
  logic                irq_ff;
  logic                start_ff;
  logic                busy_q_ff;
  logic                settle_q_ff;
  logic                meas_lvl_ff;
  logic                meas_prev_ff;
  logic                ref_lvl_ff;
  logic                ref_prev_ff;
  ref_state_t          ref_state_ff;
  logic [3:0]          settle_cnt_ff;
  logic [REFERENCE_SOURCE_SELECT_W-1:0] reference_source_select_q_ff;
  logic [31:0]         rd_word;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A write takes effect on the edge where the master sees ack
  wire logic        bus_req  = wb_cyc_i & wb_stb_i;
  wire logic        wr_fire  = bus_req & wb_we_i & ack_ff;
  wire logic [9:0]  adr_word = {wb_adr_i[9:2], 2'b00};
  wire logic        hit_ctrl = (adr_word == OFS_CTRL);
  wire logic        hit_mode = (adr_word == OFS_MODE);
  wire logic        hit_ier  = (adr_word == OFS_IER);
  wire logic        hit_idr  = (adr_word == OFS_IDR);
  wire logic        hit_icr  = (adr_word == OFS_ICR);
  wire logic        lane0_wr = wr_fire & wb_sel_i[0];

  // One-shot write strobes; zero bits leave state alone
  wire logic [1:0]  ier_bits = (lane0_wr & hit_ier) ? wb_dat_i[1:0] : 2'b00;
  wire logic [1:0]  idr_bits = (lane0_wr & hit_idr) ? wb_dat_i[1:0] : 2'b00;
  wire logic [1:0]  icr_bits = (lane0_wr & hit_icr) ? wb_dat_i[1:0] : 2'b00;
  wire logic        start_wr = lane0_wr & hit_ctrl & wb_dat_i[CTRL_START_BIT];

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  wire logic                refcen = mode_ff[REFCEN_BIT];
  wire logic [MEASURED_SOURCE_SELECT_W-1:0] measured_source_select = mode_ff[MEASURED_SOURCE_SELECT_LSB +: MEASURED_SOURCE_SELECT_W];
  wire logic [REFNUM_W-1:0] refnum = mode_ff[REFNUM_LSB +: REFNUM_W];
  wire logic [REFERENCE_SOURCE_SELECT_W-1:0] reference_source_select = mode_ff[REFERENCE_SOURCE_SELECT_LSB +: REFERENCE_SOURCE_SELECT_W];

  // Byte lanes written independently; unused bits never stored
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mode_lane
      assign nxt_mode[8*gi +: 8] = (wr_fire & hit_mode & wb_sel_i[gi])
                                   ? (wb_dat_i[8*gi +: 8] & MODE_WMASK[8*gi +: 8])
                                   : mode_ff[8*gi +: 8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  // Codes 9 and 20..31 are reserved and select a stopped source
  wire logic msr_code_ok = (measured_source_select <= MSR_FAST_RC_DBG) &&
                           (measured_source_select != (MSR_PLL_B + 5'h01));
  wire logic msr_pick    = msr_code_ok ? measured_clock_src[measured_source_select] : 1'b0;

  // Reserved reference codes also select a stopped source
  wire logic ref_code_ok = (reference_source_select <= REF_GCLK0);
  wire logic ref_pick    = (ref_code_ok & refcen)
                           ? reference_clock_src[reference_source_select[1:0]] : 1'b0;

  // Both clocks sampled on the bus clock; rising edges become ticks
  wire logic meas_tick = meas_lvl_ff & ~meas_prev_ff;
  wire logic ref_tick  = ref_lvl_ff & ~ref_prev_ff;

  // ----------------------------------------------------------------
  // Engine hookup
  // ----------------------------------------------------------------
  assign mif.start     = start_ff;
  assign mif.refnum    = refnum;
  assign mif.meas_tick = meas_tick;
  assign mif.ref_tick  = ref_tick;

  meter_engine u_engine (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .m       (mif)
  );

  // ----------------------------------------------------------------
  // Interrupt next state
  // ----------------------------------------------------------------
  wire logic settling = (ref_state_ff == RS_SETTLE);

  // Falling edges of busy and settling are the two events
  wire logic [1:0] events = {settle_q_ff & ~settling,
                             busy_q_ff & ~mif.busy};

  // Enable and disable target different addresses, so never collide
  assign nxt_mask = (mask_ff | ier_bits) & ~idr_bits;

  // An event in the clearing cycle survives: set beats clear
  assign nxt_pend = (pend_ff & ~icr_bits) | events;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Write-only and unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (adr_word)
      OFS_MODE:   rd_word = mode_ff;
      OFS_STATUS: rd_word = {30'h0, settling, mif.busy};
      OFS_VALUE:  rd_word = {8'h00, mif.value};
      OFS_IMR:    rd_word = {30'h0, mask_ff};
      OFS_ISR:    rd_word = {30'h0, pend_ff};
      OFS_REV:    rd_word = {12'h000, REV_VARIANT, 4'h0, REV_NUMBER};
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Wishbone handshake
  // ----------------------------------------------------------------
  // Ack one cycle after the request; dropped in the following cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req & ~ack_ff) begin
        rdata_ff <= wb_we_i ? 32'h0000_0000 : rd_word;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ----------------------------------------------------------------
  // Configuration and interrupt state
  // ----------------------------------------------------------------
  // Writes to mask, status and revision offsets have no write path
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_ff <= RST_MODE;
      mask_ff <= RST_IRQ;
      pend_ff <= RST_IRQ;
      irq_ff  <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      mask_ff <= nxt_mask;
      pend_ff <= nxt_pend;
      irq_ff  <= |(nxt_pend & nxt_mask);
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // Start request and event edge history
  // ----------------------------------------------------------------
  // Start honoured only with a settled reference and no run under way;
  // otherwise the window could never close
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      start_ff    <= 1'b0;
      busy_q_ff   <= 1'b0;
      settle_q_ff <= 1'b0;
    end else begin
      start_ff    <= start_wr & ~mif.busy & ~start_ff
                     & (ref_state_ff == RS_READY);
      busy_q_ff   <= mif.busy;
      settle_q_ff <= settling;
    end
  end

  // ----------------------------------------------------------------
  // Source sampling
  // ----------------------------------------------------------------
  // Sources are taken as synchronous; one stage plus history for edges
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meas_lvl_ff  <= 1'b0;
      meas_prev_ff <= 1'b0;
      ref_lvl_ff   <= 1'b0;
      ref_prev_ff  <= 1'b0;
    end else begin
      meas_lvl_ff  <= msr_pick;
      meas_prev_ff <= meas_lvl_ff;
      ref_lvl_ff   <= ref_pick;
      ref_prev_ff  <= ref_lvl_ff;
    end
  end

  // ----------------------------------------------------------------
  // Reference readiness
  // ----------------------------------------------------------------
  // Enabling the reference or changing its source restarts settling.
  // A stopped source never settles, so the flag stays high.
  wire logic reference_source_select_chg  = (reference_source_select != reference_source_select_q_ff);
  wire logic settle_done = ref_tick &&
                           (settle_cnt_ff == REF_SETTLE_EDGES - 4'h1);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ref_state_ff  <= RS_OFF;
      settle_cnt_ff <= 4'h0;
      reference_source_select_q_ff   <= '0;
    end else begin
      reference_source_select_q_ff <= reference_source_select;
      unique case (ref_state_ff)
        RS_OFF: begin
          settle_cnt_ff <= 4'h0;
          if (refcen) ref_state_ff <= RS_SETTLE;
        end
        RS_SETTLE: begin
          if (!refcen) begin
            ref_state_ff <= RS_OFF;
          end else if (reference_source_select_chg) begin
            settle_cnt_ff <= 4'h0;
          end else if (settle_done) begin
            ref_state_ff <= RS_READY;
          end else if (ref_tick) begin
            settle_cnt_ff <= settle_cnt_ff + 4'h1;
          end
        end
        RS_READY: begin
          settle_cnt_ff <= 4'h0;
          if (!refcen) begin
            ref_state_ff <= RS_OFF;
          end else if (reference_source_select_chg) begin
            ref_state_ff <= RS_SETTLE;
          end
        end
      endcase
    end
  end

endmodule // frequency_meter

// File: frequency_meter_properties.sv
// Concurrent properties on the frequency meter top ports
`timescale 1ns/1ps
module frequency_meter_properties
  import freq_meter_pkg::*;
#(
  parameter logic [11:0] REV_NUMBER  = 12'h5a1, // Arbitrary value
  parameter logic [3:0]  REV_VARIANT = 4'h0     // Arbitrary value
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Decoded bus events
  // ----------------------------------------------------------------
  logic [7:0] wrd;
  logic       rd_ack;
  logic       wr_ack;
  logic       en_take;
  logic       all_masked_ff;
  logic       nxt_all_masked;
  assign wrd     = wb_adr_i[9:2];
  assign rd_ack  = wb_ack_o && !wb_we_i;
  assign wr_ack  = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign en_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                   && wrd == OFS_IER[9:2] && wb_dat_i[1:0] != 2'h0;
  // Flag drops when an enable is taken, so it never lags the mask itself
  assign nxt_all_masked = en_take ? 1'b0
                        : (wr_ack && wrd == OFS_IDR[9:2] && wb_dat_i[1:0] == 2'h3) ? 1'b1
                        : all_masked_ff;
  always_ff @(posedge clk_sys) begin
    if (!resetn) all_masked_ff <= 1'b1;
    else all_masked_ff <= nxt_all_masked;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_timing: assert property (s_req |=> s_ack_pulse)
    else $error("ack not a single pulse one cycle after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  chk_wo_zero: assert property (rd_ack && (wrd == OFS_IDR[9:2] || wrd == OFS_ICR[9:2]
    || wrd == OFS_IER[9:2] || wrd == OFS_CTRL[9:2]) |-> wb_dat_o == 32'h0)
    else $error("write-only register read nonzero");
  chk_rev_value: assert property (rd_ack && wrd == OFS_REV[9:2]
    |-> wb_dat_o == {12'h0, REV_VARIANT, 4'h0, REV_NUMBER})
    else $error("revision register wrong");
  chk_flag_reserved: assert property (rd_ack && (wrd == OFS_IMR[9:2]
    || wrd == OFS_ISR[9:2]) |-> wb_dat_o[31:2] == 30'h0)
    else $error("reserved mask or pending bits set");
  chk_unmapped_zero: assert property (rd_ack && wrd > 8'h08 && wrd != 8'hff
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read nonzero");
  // The clear or disable lands on the ack edge, so irq is low one cycle later
  chk_clear_drops: assert property (wr_ack && wrd == OFS_ICR[9:2]
    && wb_dat_i[1:0] == 2'h3 |=> !irq)
    else $error("irq stays after full clear");
  chk_disable_drops: assert property (wr_ack && wrd == OFS_IDR[9:2]
    && wb_dat_i[1:0] == 2'h3 |=> !irq)
    else $error("irq stays after full disable");
  chk_masked_quiet: assert property (all_masked_ff |-> !irq)
    else $error("irq while every source masked");
  chk_reset_quiet: assert property ($rose(resetn) |-> !irq && !wb_ack_o)
    else $error("outputs active after reset");
endmodule // frequency_meter_properties

bind frequency_meter frequency_meter_properties #(
  .REV_NUMBER (REV_NUMBER),
  .REV_VARIANT(REV_VARIANT)
) chk_u (
  .clk_sys (clk_sys),
  .resetn  (resetn),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i (wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .irq     (irq)
);

// File: frequency_meter_tb_top.sv
// Self-checking bench for the frequency meter registers and interrupt
`timescale 1ns/1ps
module frequency_meter_tb_top
  import freq_meter_pkg::*;
;
  localparam logic [11:0] REV_N = 12'h3c7; // Arbitrary value
  localparam logic [3:0]  REV_V = 4'h9;    // Arbitrary value
  typedef struct {logic [31:0] val; logic [31:0] msk;} note_t;
  logic        clk_sys, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [9:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_data, rnd;
  logic [3:0]  wb_sel_i, ref_en, tick, reference_clock_src;
  logic [19:0] msr_en, measured_clock_src;
  int          n_errors, checked, cycles, w;
  note_t       notes[$];
  note_t       cur;

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  frequency_meter #(.REV_NUMBER(REV_N), .REV_VARIANT(REV_V)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .measured_clock_src(measured_clock_src),
    .reference_clock_src(reference_clock_src), .irq(irq));

  // One counter makes both clocks: measured rises at tick 2 mod 4, reference
  // at 8 mod 16, never together, so a window of N periods holds 4*N edges
  always @(posedge clk_sys) begin
    tick <= tick + 4'h1;
    measured_clock_src <= msr_en & {20{tick[1]}};
    reference_clock_src <= ref_en & {4{tick[3]}};
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Classic single cycle; ack is sampled before this edge's updates land
  task automatic bus(input logic we, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd_data = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] v, input logic [31:0] m = '1);
    notes.push_back('{v, m});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk_sys);
    checked++;
    if (irq !== e) begin
      n_errors++;
      $display("wrong value irq at %0t: got %h expected %h", $time, irq, e);
    end
  endtask

  task automatic wait_irq();
    for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk_sys);
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Read results are matched against the oldest note; a zero mask only polls
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.msk != 32'h0) begin
        checked++;
        if ((wb_dat_o & cur.msk) !== (cur.val & cur.msk)) begin
          n_errors++;
          $display("wrong value at %0t: got %h expected %h", $time, wb_dat_o, cur.val);
        end
      end
    end
  end

  // Hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {tick, ref_en, msr_en, n_errors, checked, cycles} = '0;
    wb_sel_i = 4'hf;
    rnd = 32'h1;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(OFS_IMR, 32'h0);
    rd(OFS_ISR, 32'h0);
    rd(OFS_REV, {12'h0, REV_V, 4'h0, REV_N});
    wr(OFS_REV, 32'hffff_ffff);
    wr(OFS_IMR, 32'h3);
    wr(OFS_ISR, 32'h3);
    rd(OFS_REV, {12'h0, REV_V, 4'h0, REV_N});
    rd(OFS_IMR, 32'h0);
    rd(OFS_ISR, 32'h0);
    rd(OFS_IDR, 32'h0);
    rd(OFS_ICR, 32'h0);
    rd(10'h100, 32'h0);
    wr(OFS_IDR, 32'h3);
    rnd = xs(rnd);
    wr(OFS_IER, {rnd[31:2], 2'h3});
    rd(OFS_IMR, 32'h3);
    rnd = xs(rnd);
    wr(OFS_IDR, {rnd[31:2], 2'h0});
    rd(OFS_IMR, 32'h3);
    wr(OFS_IDR, 32'h1);
    rd(OFS_IMR, 32'h2);
    wr(OFS_IER, 32'h1);
    rd(OFS_IMR, 32'h3);
    // Each reference code settles only if its own candidate clock runs
    for (int r = 0; r < 4; r++) begin
      ref_en <= 4'h1 << r;
      wr(OFS_MODE, 32'h8000_0200 | r);
      rd(OFS_STATUS, 32'h2, 32'h3);
      wait_irq();
      chk_irq(1'b1);
      rd(OFS_ISR, 32'h2);
      rd(OFS_STATUS, 32'h0, 32'h3);
      wr(OFS_ICR, 32'h3);
      chk_irq(1'b0);
    end
    // Every measured code; code 20 is reserved and must count nothing
    for (int c = 0; c < 21; c++) begin
      if (c == 9) continue;
      msr_en <= (c == 20) ? 20'hf_ffff : 20'h1 << c;
      wr(OFS_MODE, {1'b1, 10'h0, c[4:0], 8'h02, 5'h0, 3'h3});
      wr(OFS_CTRL, 32'h1);
      wait_irq();
      chk_irq(1'b1);
      rd(OFS_ISR, 32'h1);
      rd(OFS_VALUE, (c == 20) ? 32'h0 : 32'h8);
      wr(OFS_ICR, 32'h3);
      chk_irq(1'b0);
    end
    // Completion while masked: pending sets, irq waits for the enable
    wr(OFS_IDR, 32'h3);
    wr(OFS_CTRL, 32'h1);
    w = 0;
    do begin
      rd(OFS_STATUS, 32'h0, 32'h0);
      w++;
    end while (rd_data[0] !== 1'b0 && w < 40);
    rd(OFS_ISR, 32'h1);
    chk_irq(1'b0);
    wr(OFS_IER, 32'h1);
    chk_irq(1'b1);
    rnd = xs(rnd);
    wr(OFS_ICR, {rnd[31:2], 2'h0});
    chk_irq(1'b1);
    wr(OFS_ICR, 32'h3);
    chk_irq(1'b0);
    rd(OFS_ISR, 32'h0);
    conclude();
  end
endmodule // frequency_meter_tb_top

// File: meter_engine.sv
// Measurement engine: counts measured edges over a window of reference periods
`timescale 1ns/1ps
module meter_engine
  import freq_meter_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  meter_if.eng      m
);

  typedef enum logic [2:0] {
    EN_IDLE  = 3'b001,
    EN_ALIGN = 3'b010,
    EN_COUNT = 3'b100
  } eng_state_t;

  eng_state_t          state_ff;
  logic [REFNUM_W-1:0] periods_ff;
  logic [VALUE_W-1:0]  count_ff;
  logic [VALUE_W-1:0]  value_ff;
  logic                last_period;

  // Window closes on the reference edge that ends the programmed period count
  assign last_period = m.ref_tick && (periods_ff + 8'h01 == m.refnum);
  assign m.busy      = (state_ff != EN_IDLE);
  assign m.value     = value_ff;

  // Window opens on a reference edge so it spans whole reference periods
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_ff   <= EN_IDLE;
      periods_ff <= '0;
      count_ff   <= '0;
      value_ff   <= '0;
    end else begin
      unique case (state_ff)
        EN_IDLE: begin
          if (m.start) state_ff <= EN_ALIGN;
        end
        EN_ALIGN: begin
          periods_ff <= '0;
          count_ff   <= '0;
          if (m.ref_tick && m.refnum == 8'h00) begin
            value_ff <= '0;
            state_ff <= EN_IDLE;
          end else if (m.ref_tick) begin
            state_ff <= EN_COUNT;
          end
        end
        EN_COUNT: begin
          if (m.meas_tick) count_ff <= count_ff + 24'h000001;
          if (m.ref_tick) periods_ff <= periods_ff + 8'h01;
          if (last_period) begin
            value_ff <= m.meas_tick ? count_ff + 24'h000001 : count_ff;
            state_ff <= EN_IDLE;
          end
        end
      endcase
    end
  end

endmodule // meter_engine

// File: meter_if.sv
// Interface between the register block and the measurement engine
`timescale 1ns/1ps
interface meter_if;
  logic        start;
  logic [7:0]  refnum;
  logic        meas_tick;
  logic        ref_tick;
  logic        busy;
  logic [23:0] value;

  modport ctl (output start, refnum, meas_tick, ref_tick, input busy, value);
  modport eng (input start, refnum, meas_tick, ref_tick, output busy, value);
endinterface
